// ### hdl/timer2_map.svh
// Register offsets, field positions, reset values and timing counts of the timer block.
`ifndef TIMER2_MAP_SVH
`define TIMER2_MAP_SVH

`define ADDR_CTRL        8'hC8
`define ADDR_MODE        8'hC9
`define ADDR_RC_LO       8'hCA
`define ADDR_RC_HI       8'hCB
`define ADDR_CNT_LO      8'hCC
`define ADDR_CNT_HI      8'hCD
`define ADDR_CAP_A       8'hD0
`define ADDR_CAP_EDGE    8'hD1
`define ADDR_CAP_C       8'hD2
`define ADDR_INT_EN      8'hD3
`define ADDR_CAPV0_LO    8'hD4
`define ADDR_CAPV0_HI    8'hD5
`define ADDR_CAPV1_LO    8'hD6
`define ADDR_CAPV1_HI    8'hD7
`define ADDR_CAPV2_LO    8'hD8
`define ADDR_CAPV2_HI    8'hD9

`define CTRL_FLAG_BIT    7
`define CTRL_RUN_BIT     2
`define CTRL_CMP_BIT     0
`define MODE_RELOAD_BIT  7
`define MODE_DIV_HI      6
`define MODE_DIV_LO      4
`define MODE_CAPCLR_BIT  3
`define MODE_MCLR_BIT    2
`define MODE_TRIG_HI     1
`define MODE_TRIG_LO     0
`define CAPA_EN_LO       4
`define CAPC_FILT_LO     4
`define CAPC_CLR_BIT     3
`define INT_GLOBAL_BIT   7
`define INT_CAP_BIT      2

`define RESET_BYTE       8'h00
`define RESET_WORD       16'h0000
`define FILTER_CYCLES    4

`endif

// ### hdl/timer2_pkg.sv
// Types shared by the timer and its capture channels.
package timer2_pkg;

	typedef enum logic [1:0] {
		EDGE_RISE = 2'h0,
		EDGE_FALL = 2'h1,
		EDGE_ANY  = 2'h2
	} edge_sel_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_s;

	typedef struct packed {
		logic      en;
		logic      filt;
		edge_sel_e edge_mode;
	} chan_cfg_s;

endpackage

// ### hdl/clk_prescaler.sv
// Divides the system clock into single-cycle count ticks.
`timescale 1ns/1ps
`include "timer2_map.svh"
module clk_prescaler (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Control
	input  wire logic       run,
	input  wire logic [2:0] sel,
	// Tick
	output logic            tick
);
	logic [8:0] cnt_r;
	logic [8:0] limit;

	function automatic logic [8:0] div_limit(input logic [2:0] s);
		case (s)
			3'h0:    return 9'h000;
			3'h1:    return 9'h003;
			3'h2:    return 9'h00F;
			3'h3:    return 9'h01F;
			3'h4:    return 9'h03F;
			3'h5:    return 9'h07F;
			3'h6:    return 9'h0FF;
			default: return 9'h1FF;
		endcase
	endfunction

	assign limit = div_limit(sel); // R18
	assign tick  = run && (cnt_r >= limit); // R3 R4

	always_ff @(posedge clk) begin
		if (!rstn || !run || tick) begin
			cnt_r <= 9'h000;
		end else begin
			cnt_r <= cnt_r + 9'h001;
		end
	end

	stopped_no_tick_a: assert property (@(posedge clk) disable iff (!rstn) !run |-> !tick) // R4
		else $error("prescaler ticked while stopped");
	div4_spacing_a: assert property (@(posedge clk) disable iff (!rstn) // R18
		(tick && sel == 3'h1) |=> (!tick || sel != 3'h1) [*3])
		else $error("divide-by-four tick came too early");
endmodule

// ### hdl/cap_channel.sv
// One capture input: synchroniser, glitch filter and edge selector.
`timescale 1ns/1ps
`include "timer2_map.svh"
module cap_channel #(
	parameter int FILT = `FILTER_CYCLES
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rstn,
	// Pin and setup
	input  wire logic                 pin,
	input  timer2_pkg::chan_cfg_s     cfg,
	// Event
	output logic                      evt
);
	logic       s1_r;
	logic       s2_r;
	logic       filt_r;
	logic       prev_r;
	logic [2:0] cnt_r;
	logic       level;
	logic       rise;
	logic       fall;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
		end
	end

	// The filtered level follows only after FILT equal samples in a row.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			filt_r <= 1'b0;
			cnt_r  <= 3'h0;
		end else if (s2_r == filt_r) begin
			cnt_r <= 3'h0;
		end else if (cnt_r == 3'(FILT - 1)) begin
			filt_r <= s2_r; // R8
			cnt_r  <= 3'h0;
		end else begin
			cnt_r <= cnt_r + 3'h1;
		end
	end

	assign level = cfg.filt ? filt_r : s2_r; // R8

	always_ff @(posedge clk) begin
		if (!rstn) begin
			prev_r <= 1'b0;
		end else begin
			prev_r <= level;
		end
	end

	assign rise = level && !prev_r;
	assign fall = !level && prev_r;

	always_comb begin
		case (cfg.edge_mode)
			timer2_pkg::EDGE_RISE: evt = cfg.en && rise; // R9 R10
			timer2_pkg::EDGE_FALL: evt = cfg.en && fall; // R9 R10
			default:               evt = cfg.en && (rise || fall); // R9 R10
		endcase
	end

	filter_width_a: assert property (@(posedge clk) disable iff (!rstn) // R8
		$changed(filt_r) |-> ($past(s2_r) == filt_r) && ($past(s2_r, 2) == filt_r)
			&& ($past(s2_r, 3) == filt_r) && ($past(s2_r, 4) == filt_r))
		else $error("filter passed a short pulse");
	disabled_quiet_a: assert property (@(posedge clk) disable iff (!rstn) !cfg.en |-> !evt) // R10
		else $error("disabled channel raised an event");
	rise_only_a: assert property (@(posedge clk) disable iff (!rstn) // R9
		(evt && cfg.edge_mode == timer2_pkg::EDGE_RISE) |-> (level && !prev_r))
		else $error("rising mode fired on another edge");
endmodule

// ### hdl/timer2_capture_compare.sv
// 16-bit timer with reload/compare, three input-capture channels and a byte register port.
//
// What this block does
// R1 - Counter is two bytes counting as one.
// R2 - Select bit picks auto-reload or compare mode.
// R3 - Counter clocked by prescaled system clock.
// R4 - Counter advances only while run bit set.
// R5 - Reload enable copies reload value on event.
// R6 - Reload event is overflow or capture channel.
// R7 - Mode capture-clear zeroes counter without reload.
// R8 - Optional filter rejects pulses under four cycles.
// R9 - Per-channel rising, falling or either edge.
// R10 - Software enables channel; disabled channel ignored.
// R11 - Valid edge copies counter into capture registers.
// R12 - Valid edge sets that channel's capture flag.
// R13 - Shared request when flag and enables set.
// R14 - Software clears capture flags; hardware never does.
// R15 - Capture auto-clear zeroes counter after capture.
// R16 - Compare match sets overflow/match flag.
// R17 - Match auto-clear zeroes counter after match.
// R18 - Divider codes give 1,4,16..512.
// R19 - Trigger codes: overflow, channel 0, 1, 2.
// R20 - Overflow also sets flag; software clears it.
// R21 - Stopped counter keeps its count.
// R22 - Capture holds until next edge; counter wraps.
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "timer2_map.svh"
module timer2_capture_compare (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rstn,
	// Register port
	input  timer2_pkg::bus_req_s      bus_req,
	output logic [7:0]                rd_data,
	// Capture pins
	input  wire logic                 capture_input_a,
	input  wire logic                 capture_input_b,
	input  wire logic                 capture_input_c,
	// Status outputs
	output logic                      overflow_match_flag,
	output logic                      capture_irq
);
	logic                        run_bit_r;
	logic                        compare_reload_select_r;
	logic                        overflow_match_flag_r;
	logic [7:0]                  counter_mode_reg_r;
	logic [15:0]                 reload_compare_r;
	logic [15:0]                 cnt_r;
	logic [15:0]                 cnt_nxt;
	logic [2:0]                  channel_enable_r;
	logic [2:0]                  capture_flag_r;
	logic [5:0]                  capture_edge_control_r;
	logic [2:0]                  filter_enable_r;
	logic                        capture_auto_clear_r;
	logic                        capture_int_enable_r;
	logic                        global_int_enable_r;
	logic [15:0]                 capv_r [3];
	logic [7:0]                  rd_data_r;
	logic [7:0]                  rd_nxt;
	logic                        irq_r;
	logic                        tick;
	logic [2:0]                  cap_evt;
	logic [2:0]                  pins;
	logic                        ovf;
	logic                        match;
	logic                        any_cap;
	logic                        cap_reload;
	logic                        cap_clear;
	logic [1:0]                  trig_sel;
	logic                        reload_enable;
	logic                        mode_cap_clear;
	logic                        match_auto_clear;
	timer2_pkg::chan_cfg_s       cfg [3];

	function automatic logic wr_at(input timer2_pkg::bus_req_s r, input logic [7:0] a);
		return r.wr && (r.addr == a);
	endfunction

	assign reload_enable    = counter_mode_reg_r[`MODE_RELOAD_BIT];
	assign mode_cap_clear   = counter_mode_reg_r[`MODE_CAPCLR_BIT];
	assign match_auto_clear = counter_mode_reg_r[`MODE_MCLR_BIT];
	assign trig_sel         = counter_mode_reg_r[`MODE_TRIG_HI:`MODE_TRIG_LO];
	assign pins             = {capture_input_c, capture_input_b, capture_input_a};

	clk_prescaler u_prescaler (
		.clk  (clk),
		.rstn (rstn),
		.run  (run_bit_r),
		.sel  (counter_mode_reg_r[`MODE_DIV_HI:`MODE_DIV_LO]),
		.tick (tick)
	);

	for (genvar i = 0; i < 3; i++) begin : g_chan
		assign cfg[i].en        = channel_enable_r[i];
		assign cfg[i].filt      = filter_enable_r[i];
		assign cfg[i].edge_mode = timer2_pkg::edge_sel_e'(capture_edge_control_r[2*i +: 2]);

		cap_channel u_chan (
			.clk  (clk),
			.rstn (rstn),
			.pin  (pins[i]),
			.cfg  (cfg[i]),
			.evt  (cap_evt[i])
		);
	end

	assign any_cap = |cap_evt;

	// A capture reloads only in auto-reload mode when the trigger names that channel.
	assign cap_reload = !compare_reload_select_r && reload_enable && (trig_sel != 2'h0)
		&& cap_evt[trig_sel - 2'h1] && !mode_cap_clear; // R5 R6 R19
	assign cap_clear = any_cap && (capture_auto_clear_r
		|| (mode_cap_clear && !compare_reload_select_r)); // R7 R15

	always_comb begin
		cnt_nxt = cnt_r;
		ovf     = 1'b0;
		match   = 1'b0;
		if (tick) begin
			cnt_nxt = cnt_r + 16'h0001; // R1 R3 R22
			ovf     = (cnt_r == 16'hFFFF);
			match   = compare_reload_select_r && (cnt_nxt == reload_compare_r); // R16
			if (ovf && !compare_reload_select_r && reload_enable && trig_sel == 2'h0) begin
				cnt_nxt = reload_compare_r; // R5 R6 R19
			end
			if (match && match_auto_clear) begin
				cnt_nxt = `RESET_WORD; // R17
			end
		end
		if (cap_reload) begin
			cnt_nxt = reload_compare_r; // R5
		end
		if (cap_clear) begin
			cnt_nxt = `RESET_WORD; // R7 R15
		end
		// A software write to a counter byte takes that byte over.
		if (wr_at(bus_req, `ADDR_CNT_LO)) begin
			cnt_nxt[7:0] = bus_req.wdata;
		end
		if (wr_at(bus_req, `ADDR_CNT_HI)) begin
			cnt_nxt[15:8] = bus_req.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnt_r <= `RESET_WORD;
		end else begin
			cnt_r <= cnt_nxt; // R21
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			run_bit_r               <= 1'b0;
			compare_reload_select_r <= 1'b0;
			overflow_match_flag_r   <= 1'b0;
		end else begin
			if (wr_at(bus_req, `ADDR_CTRL)) begin
				run_bit_r               <= bus_req.wdata[`CTRL_RUN_BIT]; // R4
				compare_reload_select_r <= bus_req.wdata[`CTRL_CMP_BIT]; // R2
				overflow_match_flag_r   <= bus_req.wdata[`CTRL_FLAG_BIT] || ovf || match; // R20
			end else if (ovf || match) begin
				overflow_match_flag_r <= 1'b1; // R16 R20
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			counter_mode_reg_r <= `RESET_BYTE;
			reload_compare_r   <= `RESET_WORD;
		end else begin
			if (wr_at(bus_req, `ADDR_MODE)) begin
				counter_mode_reg_r <= bus_req.wdata;
			end
			if (wr_at(bus_req, `ADDR_RC_LO)) begin
				reload_compare_r[7:0] <= bus_req.wdata;
			end
			if (wr_at(bus_req, `ADDR_RC_HI)) begin
				reload_compare_r[15:8] <= bus_req.wdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			channel_enable_r       <= 3'h0;
			capture_edge_control_r <= 6'h00;
			filter_enable_r        <= 3'h0;
			capture_auto_clear_r   <= 1'b0;
			capture_int_enable_r   <= 1'b0;
			global_int_enable_r    <= 1'b0;
		end else begin
			if (wr_at(bus_req, `ADDR_CAP_A)) begin
				channel_enable_r <= bus_req.wdata[`CAPA_EN_LO +: 3]; // R10
			end
			if (wr_at(bus_req, `ADDR_CAP_EDGE)) begin
				capture_edge_control_r <= bus_req.wdata[5:0]; // R9
			end
			if (wr_at(bus_req, `ADDR_CAP_C)) begin
				filter_enable_r      <= bus_req.wdata[`CAPC_FILT_LO +: 3]; // R8
				capture_auto_clear_r <= bus_req.wdata[`CAPC_CLR_BIT]; // R15
			end
			if (wr_at(bus_req, `ADDR_INT_EN)) begin
				capture_int_enable_r <= bus_req.wdata[`INT_CAP_BIT];
				global_int_enable_r  <= bus_req.wdata[`INT_GLOBAL_BIT];
			end
		end
	end

	// Flags are cleared only by software; a new edge in the same cycle wins.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			capture_flag_r <= 3'h0;
		end else if (wr_at(bus_req, `ADDR_CAP_A)) begin
			capture_flag_r <= bus_req.wdata[2:0] | cap_evt; // R12 R14
		end else begin
			capture_flag_r <= capture_flag_r | cap_evt; // R12 R14
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			for (int i = 0; i < 3; i++) begin
				capv_r[i] <= `RESET_WORD;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (cap_evt[i]) begin
					capv_r[i] <= cnt_r; // R11 R22
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= (|capture_flag_r) && capture_int_enable_r && global_int_enable_r; // R13
		end
	end

	always_comb begin
		case (bus_req.addr)
			`ADDR_CTRL:     rd_nxt = {overflow_match_flag_r, 4'h0, run_bit_r, 1'b0, compare_reload_select_r};
			`ADDR_MODE:     rd_nxt = counter_mode_reg_r;
			`ADDR_RC_LO:    rd_nxt = reload_compare_r[7:0];
			`ADDR_RC_HI:    rd_nxt = reload_compare_r[15:8];
			`ADDR_CNT_LO:   rd_nxt = cnt_r[7:0];
			`ADDR_CNT_HI:   rd_nxt = cnt_r[15:8];
			`ADDR_CAP_A:    rd_nxt = {1'b0, channel_enable_r, 1'b0, capture_flag_r};
			`ADDR_CAP_EDGE: rd_nxt = {2'h0, capture_edge_control_r};
			`ADDR_CAP_C:    rd_nxt = {1'b0, filter_enable_r, capture_auto_clear_r, 3'h0};
			`ADDR_INT_EN:   rd_nxt = {global_int_enable_r, 4'h0, capture_int_enable_r, 2'h0};
			`ADDR_CAPV0_LO: rd_nxt = capv_r[0][7:0];
			`ADDR_CAPV0_HI: rd_nxt = capv_r[0][15:8];
			`ADDR_CAPV1_LO: rd_nxt = capv_r[1][7:0];
			`ADDR_CAPV1_HI: rd_nxt = capv_r[1][15:8];
			`ADDR_CAPV2_LO: rd_nxt = capv_r[2][7:0];
			`ADDR_CAPV2_HI: rd_nxt = capv_r[2][15:8];
			default:        rd_nxt = `RESET_BYTE;
		endcase
	end

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rd_data_r <= `RESET_BYTE;
		end else begin
			rd_data_r <= bus_req.rd ? rd_nxt : `RESET_BYTE;
		end
	end

	assign rd_data             = rd_data_r;
	assign overflow_match_flag = overflow_match_flag_r;
	assign capture_irq         = irq_r;

	sequence quiet_s;
		!bus_req.wr && !any_cap;
	endsequence

	sequence irq_cause_s;
		(|capture_flag_r) && capture_int_enable_r && global_int_enable_r;
	endsequence

	count_hold_a: assert property (@(posedge clk) disable iff (!rstn) // R21
		(!run_bit_r && !bus_req.wr && !any_cap) ##1 (!run_bit_r && !bus_req.wr && !any_cap)
		|=> $stable(cnt_r) && cnt_r == $past(cnt_r, 2))
		else $error("stopped counter moved");
	count_step_a: assert property (@(posedge clk) disable iff (!rstn) // R1
		(quiet_s ##0 (tick && !compare_reload_select_r && cnt_r != 16'hFFFF))
		|=> cnt_r == $past(cnt_r) + 16'h0001)
		else $error("counter did not step by one");
	wrap_zero_a: assert property (@(posedge clk) disable iff (!rstn) // R22
		(quiet_s ##0 (tick && !reload_enable && cnt_r == 16'hFFFF)) |=> cnt_r == 16'h0000)
		else $error("counter did not wrap to zero");
	ovf_reload_a: assert property (@(posedge clk) disable iff (!rstn) // R5
		(quiet_s ##0 (tick && !compare_reload_select_r && reload_enable && trig_sel == 2'h0
			&& cnt_r == 16'hFFFF)) |=> cnt_r == $past(reload_compare_r))
		else $error("overflow did not reload");
	cmp_no_reload_a: assert property (@(posedge clk) disable iff (!rstn) // R2
		(quiet_s ##0 (tick && compare_reload_select_r && reload_compare_r != 16'h0000
			&& cnt_r == 16'hFFFF)) |=> cnt_r == 16'h0000)
		else $error("compare mode reloaded on overflow");
	flag_set_a: assert property (@(posedge clk) disable iff (!rstn) // R16 R20
		(tick && (cnt_r == 16'hFFFF || (compare_reload_select_r && cnt_r + 16'h0001 == reload_compare_r)))
		|=> overflow_match_flag_r)
		else $error("overflow or match left flag clear");
	flag_sticky_a: assert property (@(posedge clk) disable iff (!rstn) // R20
		(overflow_match_flag_r && !wr_at(bus_req, `ADDR_CTRL)) |=> overflow_match_flag_r)
		else $error("flag cleared without software");
	match_clear_a: assert property (@(posedge clk) disable iff (!rstn) // R17
		(quiet_s ##0 (tick && compare_reload_select_r && match_auto_clear
			&& cnt_r + 16'h0001 == reload_compare_r)) |=> cnt_r == 16'h0000)
		else $error("match did not clear counter");
	capture_copy_a: assert property (@(posedge clk) disable iff (!rstn) // R11
		cap_evt[0] |=> capv_r[0] == $past(cnt_r))
		else $error("capture did not copy counter");
	capture_flag_a: assert property (@(posedge clk) disable iff (!rstn) // R12 R14
		cap_evt[1] |=> capture_flag_r[1] ##1 (capture_flag_r[1] || $past(wr_at(bus_req, `ADDR_CAP_A))))
		else $error("capture flag not set or lost");
	cap_clear_a: assert property (@(posedge clk) disable iff (!rstn) // R7 R15
		(any_cap && !bus_req.wr && (capture_auto_clear_r || (mode_cap_clear && !compare_reload_select_r)))
		|=> cnt_r == 16'h0000)
		else $error("capture did not clear counter");
	irq_req_a: assert property (@(posedge clk) disable iff (!rstn) // R13
		irq_cause_s |=> capture_irq)
		else $error("interrupt request missing");
	irq_quiet_a: assert property (@(posedge clk) disable iff (!rstn) // R13
		!((|capture_flag_r) && capture_int_enable_r && global_int_enable_r) |=> !capture_irq)
		else $error("interrupt request without cause");
endmodule

// ### tb/pulse_src.sv
// External pulse source driving the three capture pins.
`timescale 1ns/1ps
module pulse_src (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Request
	input  wire logic       go,
	input  wire logic [1:0] ch,
	input  wire logic [7:0] width,
	// Pins
	output logic [2:0]      pins
);
	logic [7:0] left_r;
	logic [1:0] sel_r;

	// A request starts a high pulse of the given width on one pin, the others stay low.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			left_r <= 8'h00;
			sel_r  <= 2'h0;
		end else if (go) begin
			left_r <= width;
			sel_r  <= ch;
		end else if (left_r != 8'h00) begin
			left_r <= left_r - 8'h01;
		end
	end

	assign pins = (left_r != 8'h00) ? (3'h1 << sel_r) : 3'h0;
endmodule

// ### tb/timer2_capture_compare_tb.sv
// Self-checking bench for the timer with capture channels.
`timescale 1ns/1ps
`include "timer2_map.svh"
module timer2_capture_compare_tb;
	logic                 clk;
	logic                 rstn;
	timer2_pkg::bus_req_s bus_req;
	logic [7:0]           rd_data;
	logic                 go;
	logic [1:0]           ch;
	logic [7:0]           width;
	logic [2:0]           pins;
	logic                 overflow_match_flag;
	logic                 capture_irq;
	int                   mismatches;
	int                   compares;
	logic [15:0]          seed;
	logic [15:0]          v;
	logic [15:0]          r;
	logic [15:0]          got;
	logic [7:0]           b8;
	logic [15:0]          capv [3];

	timer2_capture_compare timer2_capture_compare_inst (
		.clk                (clk),
		.rstn               (rstn),
		.bus_req            (bus_req),
		.rd_data            (rd_data),
		.capture_input_a    (pins[0]),
		.capture_input_b    (pins[1]),
		.capture_input_c    (pins[2]),
		.overflow_match_flag(overflow_match_flag),
		.capture_irq        (capture_irq)
	);

	pulse_src pulse_src_inst (
		.clk  (clk),
		.rstn (rstn),
		.go   (go),
		.ch   (ch),
		.width(width),
		.pins (pins)
	);

	always #5 clk = ~clk;

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic int div_of(input int code);
		return (code == 0) ? 1 : (code == 1) ? 4 : (16 << (code - 2));
	endfunction

	function automatic logic [15:0] ext(input logic b);
		return {15'h0000, b};
	endfunction

	function automatic logic [15:0] inr(input logic [15:0] g, input logic [15:0] lo, input logic [15:0] hi);
		return ext((g >= lo) && (g <= hi));
	endfunction

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= {a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus_req <= {a, d, 1'b0, 1'b0};
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		bus_req <= {a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus_req <= {a, 8'h00, 1'b0, 1'b0};
		#1 d = rd_data;
	endtask

	task automatic wr16(input logic [7:0] a, input logic [15:0] d);
		wr(a, d[7:0]);
		wr(a + 8'h01, d[15:8]);
	endtask

	task automatic rd16(input logic [7:0] a, output logic [15:0] d);
		logic [7:0] lo;
		logic [7:0] hi;
		rd(a, lo);
		rd(a + 8'h01, hi);
		d = {hi, lo};
	endtask

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic pulse(input logic [1:0] c, input logic [7:0] w);
		@(posedge clk);
		go    <= 1'b1;
		ch    <= c;
		width <= w;
		@(posedge clk);
		go <= 1'b0;
	endtask

	task automatic give_verdict;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		#900000;
		mismatches++;
		$display("[ERR] run length expected end seen limit");
		give_verdict;
	end

	initial begin
		clk        = 1'b0;
		rstn       = 1'b0;
		bus_req    = '0;
		go         = 1'b0;
		ch         = 2'h0;
		width      = 8'h00;
		mismatches = 0;
		compares   = 0;
		seed       = 16'h5450;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		for (int a = 8'hC8; a <= 8'hDA; a++) begin
			rd((a == 8'hDA) ? 8'h00 : a[7:0], b8);
			chk("reset read", 16'h0000, {8'h00, b8});
		end
		$display("test reset done");
		for (int c = 0; c < 8; c++) begin
			wr16(`ADDR_CNT_LO, 16'h12FE);
			wr(`ADDR_MODE, {1'b0, c[2:0], 4'h0});
			wr(`ADDR_CTRL, 8'h04);
			repeat (8 * div_of(c) - 2) @(posedge clk);
			wr(`ADDR_CTRL, 8'h00);
			rd16(`ADDR_CNT_LO, got);
			chk("count", 16'h0001, inr(got, 16'h1305, 16'h1307));
			repeat (20) @(posedge clk);
			rd16(`ADDR_CNT_LO, v);
			chk("held count", got, v);
		end
		$display("test prescaler done");
		wr(`ADDR_MODE, 8'h00);
		wr16(`ADDR_CNT_LO, 16'hFFFC);
		wr(`ADDR_CTRL, 8'h04);
		repeat (10) @(posedge clk);
		chk("overflow flag", 16'h0001, ext(overflow_match_flag));
		wr(`ADDR_CTRL, 8'h00);
		repeat (2) @(posedge clk);
		chk("cleared flag", 16'h0000, ext(overflow_match_flag));
		rd16(`ADDR_CNT_LO, got);
		chk("wrap count", 16'h0001, inr(got, 16'h0001, 16'h000F));
		seed = lfsr(seed);
		r = {1'b0, seed[14:0]};
		wr16(`ADDR_RC_LO, r);
		wr(`ADDR_MODE, 8'h80);
		wr16(`ADDR_CNT_LO, 16'hFFFC);
		wr(`ADDR_CTRL, 8'h04);
		repeat (10) @(posedge clk);
		wr(`ADDR_CTRL, 8'h00);
		rd16(`ADDR_CNT_LO, got);
		chk("overflow reload", 16'h0001, inr(got, r, r + 16'h000F));
		wr16(`ADDR_CNT_LO, 16'hFFFC);
		wr(`ADDR_CTRL, 8'h05);
		repeat (10) @(posedge clk);
		chk("compare overflow flag", 16'h0001, ext(overflow_match_flag));
		wr(`ADDR_CTRL, 8'h01);
		rd16(`ADDR_CNT_LO, got);
		chk("compare wrap", 16'h0001, inr(got, 16'h0001, 16'h000F));
		$display("test overflow done");
		wr16(`ADDR_RC_LO, 16'h0030);
		for (int m = 0; m < 2; m++) begin
			wr16(`ADDR_CNT_LO, 16'h0000);
			wr(`ADDR_MODE, (m == 1) ? 8'h04 : 8'h00);
			wr(`ADDR_CTRL, 8'h04 | m[7:0]);
			repeat (60) @(posedge clk);
			chk("match flag", ext(m == 1), ext(overflow_match_flag));
			wr(`ADDR_CTRL, m[7:0]);
			rd16(`ADDR_CNT_LO, got);
			chk("match count", 16'h0001, inr(got, m ? 16'h0000 : 16'h0031, m ? 16'h002F : 16'h0050));
		end
		$display("test compare done");
		wr(`ADDR_CTRL, 8'h00);
		wr(`ADDR_MODE, 8'h00);
		wr(`ADDR_INT_EN, 8'h84);
		wr(`ADDR_CAP_EDGE, 8'h24);
		wr(`ADDR_CAP_A, 8'h70);
		for (int c = 0; c < 3; c++) begin
			seed = lfsr(seed);
			capv[c] = seed;
			wr16(`ADDR_CNT_LO, seed);
			pulse(c[1:0], 8'h10);
			repeat (6) @(posedge clk);
			rd(`ADDR_CAP_A, b8);
			chk("early flag", ext(c != 1), ext(b8[c]));
			repeat (16) @(posedge clk);
			rd(`ADDR_CAP_A, b8);
			chk("flag", 16'h0001, ext(b8[c]));
			chk("irq", 16'h0001, ext(capture_irq));
			rd16(8'(`ADDR_CAPV0_LO + 2 * c), got);
			chk("capture", capv[c], got);
			wr(`ADDR_CAP_A, 8'h70);
			repeat (2) @(posedge clk);
			chk("irq off", 16'h0000, ext(capture_irq));
		end
		$display("test edges done");
		wr(`ADDR_CAP_A, 8'h60);
		wr16(`ADDR_CNT_LO, 16'h5555);
		pulse(2'h0, 8'h08);
		repeat (24) @(posedge clk);
		rd(`ADDR_CAP_A, b8);
		chk("disabled flags", 16'h0060, {8'h00, b8});
		rd16(`ADDR_CAPV0_LO, got);
		chk("held capture", capv[0], got);
		wr(`ADDR_CAP_A, 8'h70);
		wr(`ADDR_CAP_C, 8'h10);
		wr16(`ADDR_CNT_LO, 16'h2222);
		for (int w = 3; w < 13; w += 9) begin
			pulse(2'h0, w[7:0]);
			repeat (24) @(posedge clk);
			rd(`ADDR_CAP_A, b8);
			chk("filtered flags", (w > 4) ? 16'h0071 : 16'h0070, {8'h00, b8});
		end
		rd16(`ADDR_CAPV0_LO, got);
		chk("filtered capture", 16'h2222, got);
		wr(`ADDR_INT_EN, 8'h04);
		repeat (2) @(posedge clk);
		chk("irq global off", 16'h0000, ext(capture_irq));
		$display("test filter done");
		wr(`ADDR_CAP_A, 8'h70);
		wr(`ADDR_CAP_C, 8'h08);
		seed = lfsr(seed);
		v = seed | 16'h0100;
		wr16(`ADDR_CNT_LO, v);
		pulse(2'h1, 8'h04);
		repeat (20) @(posedge clk);
		rd16(`ADDR_CAPV1_LO, got);
		chk("clear capture", v, got);
		rd16(`ADDR_CNT_LO, got);
		chk("auto clear", 16'h0000, got);
		wr(`ADDR_CAP_C, 8'h00);
		wr(`ADDR_CAP_EDGE, 8'h00);
		for (int c = 0; c < 4; c++) begin
			seed = lfsr(seed);
			r = seed | 16'h0001;
			wr16(`ADDR_RC_LO, r);
			wr(`ADDR_MODE, (c < 3) ? 8'(8'h81 + c) : 8'h89);
			wr16(`ADDR_CNT_LO, 16'h4320);
			pulse(2'(c % 3), 8'h04);
			repeat (16) @(posedge clk);
			rd16(`ADDR_CNT_LO, got);
			chk("capture reload", (c < 3) ? r : 16'h0000, got);
		end
		$display("test capture reload done");
		give_verdict;
	end
endmodule
